// >>> src/rpf_pkg.sv
package rpf_pkg;

    // Bus geometry
    localparam int unsigned RPF_ADDR_W     = 8;
    localparam int unsigned RPF_DATA_W     = 32;
    localparam int unsigned RPF_STRB_W     = 4;
    localparam int unsigned RPF_PORTS      = 4;

    // Byte addresses of the registers
    localparam logic [7:0]  RPF_CTRL_ADDR  = 8'h20;
    localparam logic [7:0]  RPF_HAZ_ADDR   = 8'h24;

    // Field positions inside the control byte
    localparam int unsigned RPF_OFF_LSB    = 4;
    localparam int unsigned RPF_SEL_LSB    = 0;

    // Values after reset
    localparam logic [3:0]  RPF_OFF_RST    = 4'hf;
    localparam logic [3:0]  RPF_SEL_RST    = 4'h0;
    localparam logic [3:0]  RPF_HAZ_RST    = 4'h0;

    // Write and read responses
    localparam logic [1:0]  RPF_RESP_OKAY  = 2'b00;
    localparam logic [1:0]  RPF_RESP_SLV   = 2'b10;

    // Control byte: bits 7:4 forward off, bits 3:0 output select
    typedef struct packed {
        logic [3:0] fwd_off;
        logic [3:0] out_sel;
    } rpf_ctrl_t;

    // Steering view presented to the forwarding engines
    typedef struct packed {
        logic [3:0] fwd_en;
        logic [3:0] to_csi1;
        logic [3:0] csi0_mask;
        logic [3:0] csi1_mask;
    } rpf_route_t;

    // One write data beat
    typedef struct packed {
        logic [31:0] data;
        logic [3:0]  strb;
    } rpf_wbeat_t;

    typedef enum logic [0:0] {
        RPF_B_IDLE = 1'b0,
        RPF_B_RESP = 1'b1
    } rpf_bst_t;

    typedef enum logic [0:0] {
        RPF_R_IDLE = 1'b0,
        RPF_R_DATA = 1'b1
    } rpf_rst_t;

endpackage : rpf_pkg

// >>> src/rpf_hold.sv
`timescale 1ns/10ps
module rpf_hold
    import rpf_pkg::*;
#(
    parameter int unsigned W = 8
) (
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // Incoming channel
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Held item
    output logic              full,
    output logic [W-1:0]      data,
    input  wire logic         take
);

    logic         full_ff;
    logic         nxt_full;
    logic [W-1:0] data_ff;
    logic [W-1:0] nxt_data;

    // Ready only while empty, so no item can be overwritten
    assign in_ready = !full_ff;
    assign full     = full_ff;
    assign data     = data_ff;

    always_comb begin
        nxt_full = full_ff;
        nxt_data = data_ff;
        if (take) begin
            nxt_full = 1'b0;
        end else if (in_valid && !full_ff) begin
            nxt_full = 1'b1;
            nxt_data = in_data;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            full_ff <= 1'b0;
            data_ff <= '0;
        end else begin
            full_ff <= nxt_full;
            data_ff <= nxt_data;
        end
    end

endmodule : rpf_hold

// >>> src/rpf_port_route.sv
`timescale 1ns/10ps
module rpf_port_route
    import rpf_pkg::*;
(
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Control bits of one receive port
    input  wire logic fwd_off,
    input  wire logic out_sel,
    // Steering outputs
    output logic      fwd_en,
    output logic      to_csi0,
    output logic      to_csi1
);

    logic en_ff;
    logic nxt_en;
    logic c0_ff;
    logic nxt_c0;
    logic c1_ff;
    logic nxt_c1;

    always_comb begin
        nxt_en = !fwd_off;
        nxt_c0 = !fwd_off && !out_sel;
        nxt_c1 = !fwd_off && out_sel;
    end

    // Reset state forwards nothing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            en_ff <= 1'b0;
            c0_ff <= 1'b0;
            c1_ff <= 1'b0;
        end else begin
            en_ff <= nxt_en;
            c0_ff <= nxt_c0;
            c1_ff <= nxt_c1;
        end
    end

    assign fwd_en  = en_ff;
    assign to_csi0 = c0_ff;
    assign to_csi1 = c1_ff;

endmodule : rpf_port_route

// >>> src/rpf_top.sv
// Behaviour
// - Bits 7:4 turn off forwarding, ports 3:0.
// - Forward-off bits reset to one.
// - Bits 3:0 select CSI-2 output per port.
// - Output select bits reset to zero.
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/10ps
module rpf_top
    import rpf_pkg::*;
(
    // Clock and reset
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    // AXI4-Lite write address
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [RPF_ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic [2:0]              s_axi_awprot,
    // AXI4-Lite write data
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    input  wire logic [RPF_DATA_W-1:0]   s_axi_wdata,
    input  wire logic [RPF_STRB_W-1:0]   s_axi_wstrb,
    // AXI4-Lite write response
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    output logic [1:0]                   s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    input  wire logic [RPF_ADDR_W-1:0]   s_axi_araddr,
    input  wire logic [2:0]              s_axi_arprot,
    // AXI4-Lite read data
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    output logic [RPF_DATA_W-1:0]        s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    // Steering towards the forwarding engines
    output rpf_route_t                   route
);

    // Write channel holding slots
    logic                  aw_full;
    logic [RPF_ADDR_W-1:0] aw_addr;
    logic                  w_full;
    rpf_wbeat_t            w_beat;
    logic                  do_write;

    // Write response state
    rpf_bst_t   bst_ff;
    rpf_bst_t   nxt_bst;
    logic [1:0] bresp_ff;
    logic [1:0] nxt_bresp;

    // Register state
    rpf_ctrl_t  ctrl_ff;
    rpf_ctrl_t  nxt_ctrl;
    logic [3:0] haz_ff;
    logic [3:0] nxt_haz;

    // Write decode
    logic       hit_ctrl;
    logic       hit_haz;
    logic       lane0;
    rpf_ctrl_t  wr_ctrl;
    logic [3:0] remap_live;
    // Write strobes and hazard clear
    logic       wr_mapped;
    logic       wr_ctrl_en;
    logic       wr_haz_en;
    logic [3:0] haz_clear;

    // Read state
    rpf_rst_t              rst_ff;
    rpf_rst_t              nxt_rst;
    logic [RPF_DATA_W-1:0] rdata_ff;
    logic [RPF_DATA_W-1:0] nxt_rdata;
    logic [1:0]            rresp_ff;
    logic [1:0]            nxt_rresp;
    logic                  ar_take;
    // Read decode
    logic                  rd_hit_ctrl;
    logic                  rd_hit_haz;
    logic                  rd_mapped;
    logic [RPF_DATA_W-1:0] rd_word;

    // Steering fan-out
    logic [3:0] fwd_en;
    logic [3:0] to_c0;
    logic [3:0] to_c1;

    // Write address slot
    rpf_hold #(
        .W (RPF_ADDR_W)
    ) u_aw_hold (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .in_valid (s_axi_awvalid),
        .in_ready (s_axi_awready),
        .in_data  (s_axi_awaddr),
        .full     (aw_full),
        .data     (aw_addr),
        .take     (do_write)
    );

    // Write data slot; strobes travel with their word
    rpf_hold #(
        .W ($bits(rpf_wbeat_t))
    ) u_w_hold (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .in_valid (s_axi_wvalid),
        .in_ready (s_axi_wready),
        .in_data  ({s_axi_wdata, s_axi_wstrb}),
        .full     (w_full),
        .data     (w_beat),
        .take     (do_write)
    );

    // Address and data may arrive in either order; act once both are held.
    // Waiting for an idle response keeps a pending answer from being lost.
    assign do_write = aw_full && w_full && (bst_ff == RPF_B_IDLE);

    // Decode of the held address; low bits and protection are ignored
    assign hit_ctrl   = (aw_addr[7:2] == RPF_CTRL_ADDR[7:2]);
    assign hit_haz    = (aw_addr[7:2] == RPF_HAZ_ADDR[7:2]);
    assign wr_mapped  = hit_ctrl || hit_haz;
    assign lane0      = w_beat.strb[0];
    assign wr_ctrl_en = do_write && hit_ctrl && lane0;
    assign wr_haz_en  = do_write && hit_haz && lane0;

    // Field positions keep the byte layout in one place
    always_comb begin
        wr_ctrl         = '0;
        wr_ctrl.fwd_off = w_beat.data[RPF_OFF_LSB +: RPF_PORTS];
        wr_ctrl.out_sel = w_beat.data[RPF_SEL_LSB +: RPF_PORTS];
    end

    // Write-one-to-clear mask for the hazard flags
    assign haz_clear = w_beat.data[3:0] & {4{wr_haz_en}};

    // Flags a port remapped while its forwarding was live; software
    // should switch the port off first, so a set flag marks misuse
    always_comb begin
        remap_live = '0;
        for (int unsigned p = 0; p < RPF_PORTS; p++) begin
            remap_live[p] = wr_ctrl_en && !ctrl_ff.fwd_off[p] &&
                            (wr_ctrl.out_sel[p] != ctrl_ff.out_sel[p]);
        end
    end

    // Write response: one answer outstanding at most
    always_comb begin
        nxt_bst   = bst_ff;
        nxt_bresp = bresp_ff;
        unique case (bst_ff)
            RPF_B_IDLE: begin
                if (do_write) begin
                    nxt_bst   = RPF_B_RESP;
                    nxt_bresp = wr_mapped ? RPF_RESP_OKAY
                                          : RPF_RESP_SLV;
                end
            end
            RPF_B_RESP: begin
                if (s_axi_bready) begin
                    nxt_bst = RPF_B_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bst_ff   <= RPF_B_IDLE;
            bresp_ff <= RPF_RESP_OKAY;
        end else begin
            bst_ff   <= nxt_bst;
            bresp_ff <= nxt_bresp;
        end
    end

    // Response outputs come straight from the state flops
    assign s_axi_bvalid = (bst_ff == RPF_B_RESP);
    assign s_axi_bresp  = bresp_ff;

    // Only byte lane 0 carries register bits; upper lanes are ignored
    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (wr_ctrl_en) begin
            nxt_ctrl.fwd_off = wr_ctrl.fwd_off;
            nxt_ctrl.out_sel = wr_ctrl.out_sel;
        end
    end

    // Reset leaves every port blocked and steered to output 0
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff.fwd_off <= RPF_OFF_RST;
            ctrl_ff.out_sel <= RPF_SEL_RST;
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    // New hazard wins over a write-one clear in the same cycle,
    // so an event is never lost to a clear
    always_comb begin
        nxt_haz = haz_ff;
        if (wr_haz_en) begin
            nxt_haz = haz_ff & ~haz_clear;
        end
        nxt_haz = nxt_haz | remap_live;
    end

    // Flags stay set until software writes a one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            haz_ff <= RPF_HAZ_RST;
        end else begin
            haz_ff <= nxt_haz;
        end
    end

    // One read at a time; next address waits for the data to be taken
    assign s_axi_arready = (rst_ff == RPF_R_IDLE);
    assign ar_take       = s_axi_arvalid && s_axi_arready;

    // Decode sees the address in the cycle it is taken; only one read is
    // in flight, so no holding slot is needed
    assign rd_hit_ctrl = (s_axi_araddr[7:2] == RPF_CTRL_ADDR[7:2]);
    assign rd_hit_haz  = (s_axi_araddr[7:2] == RPF_HAZ_ADDR[7:2]);
    assign rd_mapped   = rd_hit_ctrl || rd_hit_haz;

    // Undefined bits and unmapped words read as zero
    always_comb begin
        rd_word = '0;
        if (rd_hit_ctrl) begin
            rd_word[7:0] = ctrl_ff;
        end else if (rd_hit_haz) begin
            rd_word[3:0] = haz_ff;
        end
    end

    always_comb begin
        nxt_rst   = rst_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        unique case (rst_ff)
            RPF_R_IDLE: begin
                if (ar_take) begin
                    nxt_rst   = RPF_R_DATA;
                    nxt_rdata = rd_word;
                    nxt_rresp = rd_mapped ? RPF_RESP_OKAY : RPF_RESP_SLV;
                end
            end
            RPF_R_DATA: begin
                if (s_axi_rready) begin
                    nxt_rst = RPF_R_IDLE;
                end
            end
        endcase
    end

    // Read answer stands in flops until rready
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_ff   <= RPF_R_IDLE;
            rdata_ff <= 32'h00000000;
            rresp_ff <= RPF_RESP_OKAY;
        end else begin
            rst_ff   <= nxt_rst;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end
    end

    assign s_axi_rvalid = (rst_ff == RPF_R_DATA);
    assign s_axi_rdata  = rdata_ff;
    assign s_axi_rresp  = rresp_ff;

    // Per receive port steering decode
    for (genvar p = 0; p < RPF_PORTS; p++) begin : g_port
        rpf_port_route u_route (
            .aclk    (aclk),
            .aresetn (aresetn),
            .fwd_off (ctrl_ff.fwd_off[p]),
            .out_sel (ctrl_ff.out_sel[p]),
            .fwd_en  (fwd_en[p]),
            .to_csi0 (to_c0[p]),
            .to_csi1 (to_c1[p])
        );
    end

    // Steering view; the mask pair spares the engines a decode of
    // their own
    always_comb begin
        route           = '0;
        route.fwd_en    = fwd_en;
        route.to_csi1   = to_c1;
        route.csi0_mask = to_c0;
        route.csi1_mask = to_c1;
    end

endmodule : rpf_top

// >>> dv/rpf_top_chk.sv
`timescale 1ns/10ps
module rpf_top_chk
    import rpf_pkg::*;
(
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Write channels
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    // Read channels
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    // Steering
    input wire rpf_route_t  route
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && (!s_axi_bvalid || s_axi_bready);
    endsequence
    sequence s_resp_late;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence

    a_write_resp: assert property (s_wr_both |=> s_resp_late)
        else $error("write response late or early");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_read_resp: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data not one cycle after take");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data dropped");
    a_rdata_byte: assert property (s_axi_rvalid |->
        s_axi_rdata[31:8] == 24'h0)
        else $error("read data above the byte");
    a_csi0_split: assert property (route.csi0_mask ==
        (route.fwd_en & ~route.to_csi1))
        else $error("output 0 mask wrong");
    a_csi1_split: assert property (route.csi1_mask == route.to_csi1
        && (route.to_csi1 & ~route.fwd_en) == 4'h0)
        else $error("output 1 mask wrong");
    a_reset_route: assert property ($rose(aresetn) |->
        route == 16'h0 && !s_axi_bvalid && !s_axi_rvalid)
        else $error("state after reset wrong");
endmodule : rpf_top_chk

bind rpf_top rpf_top_chk rpf_top_chk_i (.*);

// >>> dv/rpf_top_bench.sv
`timescale 1ns/10ps
module rpf_top_bench
    import rpf_pkg::*;
;
    logic        aclk, aresetn;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [2:0]  s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    rpf_route_t  route;
    int          fails, num_checks;
    // Off-then-map-then-on order first, as software should do it
    logic [7:0]  vals [7] = '{8'hf5, 8'h05, 8'ha3, 8'hff, 8'h00, 8'h5c,
                             8'h3a};

    rpf_top rpf_top_i (.*);

    initial begin
        aclk = 1'h0;
        forever #50 aclk = ~aclk;
    end

    task close_out;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    function automatic logic [15:0] rt(input logic [7:0] v);
        logic [3:0] en;
        en = ~v[7:4];
        return {en, en & v[3:0], en & ~v[3:0], en & v[3:0]};
    endfunction : rt

    task do_reset;
        @(posedge aclk);
        aresetn <= 1'h0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
    endtask : do_reset

    task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
            input logic [1:0] er);
        logic pa, pw, ta, tw;
        logic [1:0] r;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        s_axi_bready  <= 1'h1;
        pa = 1'h1;
        pw = 1'h1;
        while (pa || pw) begin
            @(negedge aclk);
            ta = pa && s_axi_awready;
            tw = pw && s_axi_wready;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'h0;
            if (tw) s_axi_wvalid <= 1'h0;
            pa = pa && !ta;
            pw = pw && !tw;
        end
        ta = 1'h0;
        while (!ta) begin
            @(negedge aclk);
            ta = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
        end
        s_axi_bready <= 1'h0;
        chk("bresp", {30'h0, er}, {30'h0, r});
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic t;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready  <= 1'h1;
        t = 1'h0;
        while (!t) begin
            @(negedge aclk);
            t = s_axi_arready;
            @(posedge aclk);
        end
        s_axi_arvalid <= 1'h0;
        t = 1'h0;
        while (!t) begin
            @(negedge aclk);
            t = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
        end
        s_axi_rready <= 1'h0;
        chk("rdata", ed, d);
        chk("rresp", {30'h0, er}, {30'h0, r});
    endtask : rd

    // Far beyond the hundred or so cycles the sequence needs
    initial begin
        repeat (4000) @(posedge aclk);
        fails++;
        close_out();
    end

    initial begin
        aresetn = 1'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        {s_axi_awprot, s_axi_arprot, s_axi_wstrb} = 10'h0;
        fails = 0;
        num_checks = 0;
        do_reset();
        rd(8'h20, 32'hf0, RPF_RESP_OKAY);
        chk("route", 32'h0, {16'h0, route});
        foreach (vals[i]) begin
            wr(8'h20, {24'h0, vals[i]}, 4'h1, RPF_RESP_OKAY);
            rd(8'h20, {24'h0, vals[i]}, RPF_RESP_OKAY);
            chk("route", {16'h0, rt(vals[i])}, {16'h0, route});
        end
        wr(8'h20, 32'habcdef12, 4'hf, RPF_RESP_OKAY);
        rd(8'h20, 32'h12, RPF_RESP_OKAY);
        wr(8'h20, 32'h0, 4'h0, RPF_RESP_OKAY);
        rd(8'h20, 32'h12, RPF_RESP_OKAY);
        wr(8'h40, 32'h0, 4'h1, RPF_RESP_SLV);
        rd(8'h40, 32'h0, RPF_RESP_SLV);
        rd(8'h20, 32'h12, RPF_RESP_OKAY);
        chk("route", {16'h0, rt(8'h12)}, {16'h0, route});
        // Live remaps above flagged ports 1, 2 and 3
        rd(8'h24, 32'h0e, RPF_RESP_OKAY);
        wr(8'h24, 32'h0000000a, 4'h1, RPF_RESP_OKAY);
        rd(8'h24, 32'h04, RPF_RESP_OKAY);
        do_reset();
        rd(8'h20, 32'hf0, RPF_RESP_OKAY);
        chk("route", 32'h0, {16'h0, route});
        rd(8'h24, 32'h0, RPF_RESP_OKAY);
        close_out();
    end
endmodule : rpf_top_bench
